/* shared/etd_map.vh */
`ifndef ETD_MAP_VH
`define ETD_MAP_VH
// ******************************************
// transfer information layout, in words
// ******************************************
`define ETD_W_CTL     3'h0
`define ETD_W_SRC     3'h1
`define ETD_W_DST     3'h2
`define ETD_W_CNT     3'h3
`define ETD_W_RPT     3'h4
`define ETD_W_LAST    3'h4
`define ETD_INF_STEP  32'h00000014
`define ETD_ALIGN     2'h0
// ******************************************
// control word fields
// ******************************************
`define ETD_F_MODE    1:0
`define ETD_F_SIZE    3:2
`define ETD_F_SINC    4
`define ETD_F_DINC    5
`define ETD_F_RSIDE   6
`define ETD_F_CHAIN   7
`define ETD_F_CZERO   8
`define ETD_F_IEACH   9
`define ETD_F_IDONE   10
`define ETD_F_IPASS   11
`define ETD_F_WBDIS   12
`define ETD_F_DISP    13
`define ETD_F_SQEND   14
`define ETD_F_INDX    15
// ******************************************
// count word fields and codes
// ******************************************
`define ETD_F_UNIT    7:0
`define ETD_F_RSIZE   15:8
`define ETD_F_TCNT    31:16
`define ETD_MD_NORM   2'h0
`define ETD_MD_RPT    2'h1
`define ETD_MD_BLK    2'h2
`define ETD_SZ_B      2'h0
`define ETD_SZ_W      2'h1
`define ETD_SZ_L      2'h2
`define ETD_ONE8      8'h01
`define ETD_ONE16     16'h0001
`define ETD_SHORT_MSB 23
`endif

/* design/etd_transfer_controller.v */
// What this block does
// - normal mode: one unit per accepted activation
// - repeat mode: reload repeating address at size
// - repeat size up to 256 units
// - block mode: one block, 1 to 256 units
// - unit is byte, word or longword
// - chaining runs several transfers per activation
// - chain always, or only at zero count
// - stored sequences selected by transferred data
// - one sequence trigger source at a time
// - up to 256 sequences per trigger
// - last value read by the index-flagged transfer picks the sequence
// - sequence completes or suspends and resumes
// - short mode: bottom and top 8 MB
// - full mode reaches whole 32-bit space
// - activation may pass on to the CPU
// - optional CPU interrupt per transfer
// - optional CPU interrupt at count end
// - event link per transfer or block
// - skip info reread on repeated transfer
// - skip write-back of unchanged fixed addresses
// - write-back can be disabled
// - optional displacement on source address
`timescale 1ns/1ps
`default_nettype none
`include "etd_map.vh"
module etd_transfer_controller #(
  parameter IDW = 8
) (
  input  wire            i_sys_clk,
  input  wire            i_rst,
  input  wire            i_act_req,
  input  wire [IDW-1:0]  i_act_id,
  output wire            o_act_ack,
  input  wire [31:0]     i_vec_base,
  input  wire [31:0]     i_idx_base,
  input  wire            i_seq_en,
  input  wire [IDW-1:0]  i_seq_src,
  input  wire            i_short_addr,
  input  wire            i_rd_skip_en,
  input  wire [31:0]     i_disp,
  output wire            o_bus_req,
  output wire            o_bus_we,
  output wire [31:0]     o_bus_addr,
  output wire [1:0]      o_bus_size,
  output wire [31:0]     o_bus_wdata,
  input  wire            i_bus_ack,
  input  wire [31:0]     i_bus_rdata,
  output reg             o_cpu_irq,
  output reg  [IDW-1:0]  o_cpu_irq_id,
  output reg             o_elc_req,
  output wire            o_busy
);
  // ******************************************
  // states
  // ******************************************
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_VEC  = 8'h02;
  localparam [7:0] S_FET  = 8'h04;
  localparam [7:0] S_RD   = 8'h08;
  localparam [7:0] S_WR   = 8'h10;
  localparam [7:0] S_IDX  = 8'h20;
  localparam [7:0] S_WB   = 8'h40;
  localparam [7:0] S_FIN  = 8'h80;

  reg [7:0]     state_reg;
  reg [2:0]     wcnt_reg;
  reg [IDW-1:0] id_reg;
  reg [31:0]    info_reg;
  reg [31:0]    ctl_reg;
  reg [31:0]    src_reg;
  reg [31:0]    dst_reg;
  reg [31:0]    cnt_reg;
  reg [31:0]    rpt_reg;
  reg [31:0]    data_reg;
  reg [7:0]     blk_reg;
  reg [31:0]    cache_reg;
  reg           cache_vld_reg;
  reg           seq_act_reg;
  reg           in_seq_reg;
  reg           idx_hit_reg;
  reg [31:0]    idx_addr_reg;
  reg           resume_vld_reg;
  reg [31:0]    resume_reg;

  // ******************************************
  // decoded control fields
  // ******************************************
  wire [1:0]  mode   = ctl_reg[`ETD_F_MODE];
  wire [1:0]  usize  = ctl_reg[`ETD_F_SIZE];
  wire        is_rpt = (mode == `ETD_MD_RPT);
  wire        is_blk = (mode == `ETD_MD_BLK);
  wire [31:0] step   = (usize == `ETD_SZ_B) ? 32'h00000001 :
                       (usize == `ETD_SZ_W) ? 32'h00000002 :
                       32'h00000004;
  wire [31:0] wofs   = {27'h0000000, wcnt_reg, `ETD_ALIGN};
  wire [31:0] src_eff = ctl_reg[`ETD_F_DISP] ?
                        src_reg + i_disp : src_reg;
  wire        wb_skip = ((wcnt_reg == `ETD_W_SRC) &&
                         !ctl_reg[`ETD_F_SINC]) ||
                        ((wcnt_reg == `ETD_W_DST) &&
                         !ctl_reg[`ETD_F_DINC]);
  wire        can_skip = i_rd_skip_en && cache_vld_reg &&
                         (cache_reg == info_reg);
  wire        unit_end = (cnt_reg[`ETD_F_UNIT] == `ETD_ONE8);
  wire        blk_end  = !is_blk || (blk_reg == `ETD_ONE8);
  wire        seq_hit  = i_seq_en && (i_act_id == i_seq_src);

  // short mode folds bit 23 up so only both 8 MB ends are reached
  function [31:0] fold;
    input [31:0] a;
    input        s;
    begin
      fold = s ? {{8{a[`ETD_SHORT_MSB]}}, a[`ETD_SHORT_MSB:0]}
               : a;
    end
  endfunction

  // ******************************************
  // system bus request, held until ack
  // ******************************************
  reg [31:0] addr_mux;
  reg [31:0] wdat_mux;
  always @* begin
    addr_mux = info_reg + wofs;
    wdat_mux = data_reg;
    case (state_reg)
      S_VEC: addr_mux = i_vec_base + {22'h000000, id_reg, `ETD_ALIGN};
      S_RD:  addr_mux = fold(src_eff, i_short_addr);
      S_WR:  addr_mux = fold(dst_reg, i_short_addr);
      S_IDX: addr_mux = i_idx_base +
                        {22'h000000, data_reg[7:0], `ETD_ALIGN};
      S_WB: begin
        case (wcnt_reg)
          `ETD_W_SRC: wdat_mux = src_reg;
          `ETD_W_DST: wdat_mux = dst_reg;
          default:    wdat_mux = cnt_reg;
        endcase
      end
      default: addr_mux = info_reg + wofs;
    endcase
  end

  assign o_bus_req = (state_reg == S_VEC) || (state_reg == S_RD) ||
                     (state_reg == S_WR) || (state_reg == S_IDX) ||
                     ((state_reg == S_FET) && !can_skip) ||
                     ((state_reg == S_WB) && !wb_skip);
  assign o_bus_we   = (state_reg == S_WR) || (state_reg == S_WB);
  assign o_bus_addr = addr_mux;
  assign o_bus_size = ((state_reg == S_RD) || (state_reg == S_WR)) ?
                      usize : `ETD_SZ_L;
  assign o_bus_wdata = wdat_mux;
  assign o_act_ack  = (state_reg == S_IDLE) && i_act_req;
  assign o_busy     = (state_reg != S_IDLE);

  // ******************************************
  // sequencer
  // ******************************************
  // one process: the info words load on fetch acknowledges and addresses
  // and counters step on the write acknowledge of one state machine, so splitting gains nothing
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg      <= S_IDLE;
      wcnt_reg       <= 3'h0;
      id_reg         <= {IDW{1'b0}};
      info_reg       <= 32'h00000000;
      ctl_reg        <= 32'h00000000;
      src_reg        <= 32'h00000000;
      dst_reg        <= 32'h00000000;
      cnt_reg        <= 32'h00000000;
      rpt_reg        <= 32'h00000000;
      data_reg       <= 32'h00000000;
      blk_reg        <= 8'h00;
      cache_reg      <= 32'h00000000;
      cache_vld_reg  <= 1'b0;
      seq_act_reg    <= 1'b0;
      in_seq_reg     <= 1'b0;
      idx_hit_reg    <= 1'b0;
      idx_addr_reg   <= 32'h00000000;
      resume_vld_reg <= 1'b0;
      resume_reg     <= 32'h00000000;
      o_cpu_irq      <= 1'b0;
      o_cpu_irq_id   <= {IDW{1'b0}};
      o_elc_req      <= 1'b0;
    end else begin
      o_cpu_irq <= 1'b0;
      o_elc_req <= 1'b0;
      case (state_reg)
        // accept one activation; a suspended sequence picks up here
        S_IDLE: begin
          wcnt_reg <= `ETD_W_CTL;
          if (i_act_req) begin
            id_reg      <= i_act_id;
            seq_act_reg <= seq_hit;
            idx_hit_reg <= 1'b0;
            if (seq_hit && resume_vld_reg) begin
              info_reg   <= resume_reg;
              in_seq_reg <= 1'b1;
              state_reg  <= S_FET;
            end else begin
              in_seq_reg <= 1'b0;
              state_reg  <= S_VEC;
            end
          end
        end
        S_VEC: begin
          if (i_bus_ack) begin
            info_reg  <= i_bus_rdata;
            state_reg <= S_FET;
          end
        end
        // read the info words, or reuse them on a repeat
        S_FET: begin
          if (can_skip) begin
            blk_reg   <= cnt_reg[`ETD_F_RSIZE];
            state_reg <= S_RD;
          end else if (i_bus_ack) begin
            case (wcnt_reg)
              `ETD_W_CTL: ctl_reg <= i_bus_rdata;
              `ETD_W_SRC: src_reg <= i_bus_rdata;
              `ETD_W_DST: dst_reg <= i_bus_rdata;
              `ETD_W_CNT: cnt_reg <= i_bus_rdata;
              default:    rpt_reg <= i_bus_rdata;
            endcase
            wcnt_reg <= wcnt_reg + 3'h1;
            if (wcnt_reg == `ETD_W_CNT)
              blk_reg <= i_bus_rdata[`ETD_F_RSIZE];
            if (wcnt_reg == `ETD_W_LAST) begin
              cache_reg     <= info_reg;
              cache_vld_reg <= 1'b1;
              state_reg     <= S_RD;
            end
          end
        end
        S_RD: begin
          if (i_bus_ack) begin
            data_reg  <= i_bus_rdata;
            state_reg <= S_WR;
          end
        end
        // one unit written: step addresses and counters
        S_WR: begin
          if (i_bus_ack) begin
            if (ctl_reg[`ETD_F_SINC])
              src_reg <= src_reg + step;
            if (ctl_reg[`ETD_F_DINC])
              dst_reg <= dst_reg + step;
            if (is_rpt) begin
              cnt_reg[`ETD_F_UNIT] <= cnt_reg[`ETD_F_UNIT] - `ETD_ONE8;
              if (unit_end) begin
                // zero size field means 256 units
                cnt_reg[`ETD_F_UNIT] <= cnt_reg[`ETD_F_RSIZE];
                if (ctl_reg[`ETD_F_RSIDE])
                  src_reg <= rpt_reg;
                else
                  dst_reg <= rpt_reg;
              end
            end
            if (!blk_end) begin
              blk_reg   <= blk_reg - `ETD_ONE8;
              state_reg <= S_RD;
            end else begin
              if (!is_rpt)
                cnt_reg[`ETD_F_TCNT] <= cnt_reg[`ETD_F_TCNT] -
                                        `ETD_ONE16;
              o_elc_req <= 1'b1;
              if (ctl_reg[`ETD_F_IEACH] || (ctl_reg[`ETD_F_IDONE] &&
                  !is_rpt && (cnt_reg[`ETD_F_TCNT] == `ETD_ONE16))) begin
                o_cpu_irq    <= 1'b1;
                o_cpu_irq_id <= id_reg;
              end
              wcnt_reg <= `ETD_W_SRC;
              if (seq_act_reg && !in_seq_reg && ctl_reg[`ETD_F_INDX])
                state_reg <= S_IDX;
              else if (ctl_reg[`ETD_F_WBDIS])
                state_reg <= S_FIN;
              else
                state_reg <= S_WB;
            end
          end
        end
        // look up the chosen sequence in the index table
        S_IDX: begin
          if (i_bus_ack) begin
            idx_addr_reg <= i_bus_rdata;
            idx_hit_reg  <= 1'b1;
            in_seq_reg   <= 1'b1;
            state_reg    <= ctl_reg[`ETD_F_WBDIS] ? S_FIN : S_WB;
          end
        end
        // store back source, destination and counts
        S_WB: begin
          if (wb_skip || i_bus_ack) begin
            wcnt_reg <= wcnt_reg + 3'h1;
            if (wcnt_reg == `ETD_W_CNT)
              state_reg <= S_FIN;
          end
        end
        // decide between chain, suspend and finish
        S_FIN: begin
          wcnt_reg <= `ETD_W_CTL;
          if (ctl_reg[`ETD_F_IPASS]) begin
            o_cpu_irq    <= 1'b1;
            o_cpu_irq_id <= id_reg;
          end
          if (idx_hit_reg) begin
            idx_hit_reg <= 1'b0;
            info_reg    <= idx_addr_reg;
            state_reg   <= S_FET;
          end else if (ctl_reg[`ETD_F_CHAIN] && in_seq_reg &&
                       ctl_reg[`ETD_F_SQEND]) begin
            resume_reg     <= info_reg + `ETD_INF_STEP;
            resume_vld_reg <= 1'b1;
            state_reg      <= S_IDLE;
          end else if (ctl_reg[`ETD_F_CHAIN] &&
                       (!ctl_reg[`ETD_F_CZERO] ||
                        (cnt_reg[`ETD_F_TCNT] == 16'h0000))) begin
            info_reg  <= info_reg + `ETD_INF_STEP;
            state_reg <= S_FET;
          end else begin
            if (in_seq_reg)
              resume_vld_reg <= 1'b0;
            in_seq_reg <= 1'b0;
            state_reg  <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // etd_transfer_controller
`default_nettype wire

/* sim/etd_tc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// port protocol checks for the controller
// ******************************************
module etd_tc_monitor #(
  parameter IDW = 8
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_act_req,
  input wire logic        o_act_ack,
  input wire logic        o_bus_req,
  input wire logic        o_bus_we,
  input wire logic [31:0] o_bus_addr,
  input wire logic [1:0]  o_bus_size,
  input wire logic [31:0] o_bus_wdata,
  input wire logic        i_bus_ack,
  input wire logic        o_cpu_irq,
  input wire logic        o_elc_req,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // request taken only from idle
  a_ack_idle: assert property (o_act_ack == (i_act_req && !o_busy))
    else $error("ack not tied to idle request");
  a_ack_start: assert property (o_act_ack |=> o_busy && o_bus_req)
    else $error("no bus access after ack");
  // an access stands unchanged until acknowledged
  a_bus_hold: assert property (o_bus_req && !i_bus_ack |=>
    o_bus_req && $stable(o_bus_addr) && $stable(o_bus_we)
    && $stable(o_bus_size) && $stable(o_bus_wdata))
    else $error("bus access changed before ack");
  a_req_busy: assert property (o_bus_req |-> o_busy)
    else $error("bus access while idle");
  a_unit_code: assert property (o_bus_req |-> o_bus_size != 2'h3)
    else $error("illegal unit size");
  a_unit_align: assert property (o_bus_req |->
    (o_bus_size == 2'h2) ? (o_bus_addr[1:0] == 2'h0) :
    (o_bus_size == 2'h1) ? !o_bus_addr[0] : 1'b1)
    else $error("misaligned access");
  // event link only right after a write completes
  a_elc_write: assert property (o_elc_req |->
    $past(o_bus_req && o_bus_we && i_bus_ack))
    else $error("event link without a write");
  a_elc_single: assert property (o_elc_req |=> !o_elc_req)
    else $error("event link longer than a cycle");
  a_irq_single: assert property (o_cpu_irq |=> !o_cpu_irq)
    else $error("cpu irq longer than a cycle");
endmodule // etd_tc_monitor
bind etd_transfer_controller etd_tc_monitor #(.IDW(IDW)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_act_req(i_act_req),
  .o_act_ack(o_act_ack), .o_bus_req(o_bus_req), .o_bus_we(o_bus_we),
  .o_bus_addr(o_bus_addr), .o_bus_size(o_bus_size),
  .o_bus_wdata(o_bus_wdata), .i_bus_ack(i_bus_ack),
  .o_cpu_irq(o_cpu_irq), .o_elc_req(o_elc_req), .o_busy(o_busy));
`default_nettype wire

/* sim/etd_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// system bus memory, 1 KB, settable wait
// ******************************************
module etd_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_size,
  input  wire logic [31:0] i_wdata,
  input  wire logic [1:0]  i_wait,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [31:0] m [0:255];
  logic [31:0] last_reg = 32'h00000000;
  logic [1:0]  cnt_reg = 2'h0;
  logic [4:0]  sh;
  // byte lane offset; narrow data travels in low bits
  assign sh = {i_addr[1:0], 3'h0};
  assign o_ack = i_req && (cnt_reg == i_wait);
  // released lines show the inverse, never a stale match
  assign o_rdata = o_ack ? (m[i_addr[9:2]] >> sh) : ~last_reg;
  always @(posedge i_clk) begin
    cnt_reg <= (i_req && !o_ack) ? cnt_reg + 2'h1 : 2'h0;
    if (o_ack)
      last_reg <= o_rdata;
    if (o_ack && i_we) begin
      case (i_size)
        2'h0: m[i_addr[9:2]][sh +: 8] <= i_wdata[7:0];
        2'h1: m[i_addr[9:2]][sh +: 16] <= i_wdata[15:0];
        default: m[i_addr[9:2]] <= i_wdata;
      endcase
    end
  end
endmodule // etd_mem_model
`default_nettype wire

/* sim/tb_event_triggered_data_transfer.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
$display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_event_triggered_data_transfer;
  logic        clk = 1'b0, rst = 1'b1, act_req = 1'b0;
  logic        rd_skip = 1'b0, short_m = 1'b0;
  logic [7:0]  act_id = 8'h00, seen_id;
  logic [1:0]  wait_n = 2'h0;
  wire         ack, breq, bwe, back, irq, elc, busy;
  wire  [31:0] badr, bwd, brd;
  wire  [1:0]  bsz;
  wire  [7:0]  irq_id;
  logic        seq_en = 1'b0;
  logic [7:0]  seq_src = 8'h00;
  logic [31:0] disp = 32'h00000000, wr_adr;
  int          fail_count = 0, tests_run = 0, elc_n, irq_n, rd_n, wr_n;
  always #20 clk = ~clk;
  // vector table at address zero, index table high in memory
  etd_transfer_controller dut (
    .i_sys_clk(clk), .i_rst(rst), .i_act_req(act_req), .i_act_id(act_id),
    .o_act_ack(ack), .i_vec_base(32'h00000000), .i_idx_base(32'h00000380),
    .i_seq_en(seq_en), .i_seq_src(seq_src), .i_short_addr(short_m),
    .i_rd_skip_en(rd_skip), .i_disp(disp), .o_bus_req(breq),
    .o_bus_we(bwe), .o_bus_addr(badr), .o_bus_size(bsz), .o_bus_wdata(bwd),
    .i_bus_ack(back), .i_bus_rdata(brd), .o_cpu_irq(irq),
    .o_cpu_irq_id(irq_id), .o_elc_req(elc), .o_busy(busy));
  etd_mem_model mem (
    .i_clk(clk), .i_req(breq), .i_we(bwe), .i_addr(badr), .i_size(bsz),
    .i_wdata(bwd), .i_wait(wait_n), .o_ack(back), .o_rdata(brd));
  // ******************************************
  // helpers
  // ******************************************
  task automatic put(input [31:0] a, input [31:0] v);
    mem.m[a[9:2]] = v;
  endtask
  function automatic [31:0] rd(input [31:0] a);
    rd = mem.m[a[9:2]];
  endfunction
  task automatic info(input [31:0] a, c, s, d, n, r);
    put(a, c); put(a + 4, s); put(a + 8, d); put(a + 12, n); put(a + 16, r);
  endtask
  // one activation; counts pulses until back in idle
  task automatic fire(input [7:0] id);
    int n;
    n = 0; elc_n = 0; irq_n = 0; rd_n = 0; wr_n = 0;
    @(posedge clk); act_req <= 1'b1; act_id <= id;
    do @(negedge clk); while (!ack && n++ < 20);
    `CHK(ack, 1'b1)
    @(posedge clk); act_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      elc_n += elc; irq_n += irq;
      if (irq === 1'b1) seen_id = irq_id;
      // first write of an activation is always the data write
      if (breq && back && bwe && wr_n == 0) wr_adr = badr;
      wr_n += breq && back && bwe;
      rd_n += breq && back && !bwe;
    end while (busy !== 1'b0 && n++ < 3000);
    `CHK(busy, 1'b0)
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ******************************************
  // scenarios
  // ******************************************
  task t_normal;  // byte units, count end irq on second unit
    put(32'h0C, 32'h40); put(32'h200, 32'h11223344); put(32'h300, 32'h0);
    info(32'h40, 32'h430, 32'h201, 32'h301, 32'h00020000, 32'h0);
    fire(8'h03);
    `CHK(rd(32'h300), 32'h00003300)
    `CHK(elc_n, 1)
    `CHK(irq_n, 0)
    `CHK(rd(32'h44), 32'h00000202)
    `CHK(rd(32'h4C), 32'h00010000)
    fire(8'h03);
    `CHK(rd(32'h300), 32'h00223300)
    `CHK(irq_n, 1)
    `CHK(seen_id, 8'h03)
  endtask
  task t_block;  // three longwords, slow memory, one link event
    @(posedge clk);
    wait_n <= 2'h2; short_m <= 1'b1;
    put(32'h10, 32'h60); put(32'h31C, 32'h0);
    info(32'h60, 32'h3A, 32'h210, 32'h310, 32'h00010300, 32'h0);
    for (int k = 0; k < 3; k++) put(32'h210 + 4 * k, 32'hA0000000 + k);
    fire(8'h04);
    for (int k = 0; k < 3; k++) `CHK(rd(32'h310 + 4 * k), 32'hA0000000 + k)
    `CHK(rd(32'h31C), 32'h0)
    `CHK(elc_n, 1)
    @(posedge clk);
    wait_n <= 2'h0; short_m <= 1'b0;
  endtask
  task t_chain;  // word then longword on one activation
    put(32'h14, 32'h80); put(32'h230, 32'h0000BEEF);
    put(32'h234, 32'hCAFE0001); put(32'h330, 32'h0); put(32'h334, 32'h0);
    info(32'h80, 32'h2B4, 32'h230, 32'h330, 32'h00010000, 32'h0);
    info(32'h94, 32'h1838, 32'h234, 32'h334, 32'h00010000, 32'h0);
    fire(8'h05);
    `CHK(rd(32'h330), 32'h0000BEEF)
    `CHK(rd(32'h334), 32'hCAFE0001)
    `CHK(elc_n, 2)
    `CHK(irq_n, 2)
    `CHK(seen_id, 8'h05)
    `CHK(rd(32'h98), 32'h00000234)
    `CHK(wr_n, 5)
  endtask
  task t_repeat;  // repeat size 2, source side reloads
    @(posedge clk);
    rd_skip <= 1'b1;
    put(32'h18, 32'hC0); put(32'h220, 32'h00005AA5); put(32'h320, 32'h0);
    info(32'hC0, 32'h51, 32'h220, 32'h320, 32'h00000202, 32'h220);
    fire(8'h06);
    fire(8'h06);
    `CHK(rd(32'h320), 32'h0000005A)
    `CHK(rd(32'hC4), 32'h00000220)
    `CHK(rd(32'hCC), 32'h00000202)
    fire(8'h06);
    `CHK(rd(32'h320), 32'h000000A5)
    `CHK(rd_n, 2)
    `CHK(wr_n, 3)
    @(posedge clk);
    rd_skip <= 1'b0;
  endtask
  task t_seq;  // data-picked sequence, split in two
    put(32'h1C, 32'hE0); put(32'h20, 32'hE0); put(32'h388, 32'h100);
    put(32'h240, 32'h2); put(32'h244, 32'h11111111);
    put(32'h248, 32'h22222222);
    put(32'h340, 32'h0); put(32'h344, 32'h0); put(32'h348, 32'h0);
    info(32'hE0, 32'h9000, 32'h240, 32'h340, 32'h00010000, 32'h0);
    info(32'h100, 32'h5088, 32'h244, 32'h344, 32'h00010000, 32'h0);
    info(32'h114, 32'h1008, 32'h248, 32'h348, 32'h00010000, 32'h0);
    @(posedge clk);
    seq_en <= 1'b1; seq_src <= 8'h07;
    fire(8'h08);  // same info, but not the trigger source
    `CHK(rd(32'h340), 32'h00000002)
    `CHK(rd(32'h344), 32'h0)
    fire(8'h07);
    `CHK(rd(32'h344), 32'h11111111)
    `CHK(rd(32'h348), 32'h0)
    `CHK(elc_n, 2)
    fire(8'h07);  // resumes after the split point, no vector read
    `CHK(rd(32'h348), 32'h22222222)
    `CHK(rd_n, 6)
    `CHK(elc_n, 1)
    @(posedge clk);
    seq_en <= 1'b0;
  endtask
  task t_disp;  // displaced source, short then full, chain at zero
    put(32'h24, 32'h140); put(32'h250, 32'hFFFFFFFF);
    put(32'h260, 32'h13572468); put(32'h264, 32'h24681357);
    put(32'h350, 32'h0); put(32'h354, 32'h0);
    info(32'h140, 32'h2188, 32'h250, 32'h00800350, 32'h00020000, 32'h0);
    info(32'h154, 32'h8, 32'h264, 32'h354, 32'h00010000, 32'h0);
    @(posedge clk);
    short_m <= 1'b1; disp <= 32'h00000010;
    fire(8'h09);
    `CHK(rd(32'h350), 32'h13572468)
    `CHK(wr_adr, 32'hFF800350)
    `CHK(wr_n, 2)
    `CHK(rd(32'h354), 32'h0)
    @(posedge clk);
    short_m <= 1'b0;
    fire(8'h09);
    `CHK(wr_adr, 32'h00800350)
    `CHK(rd(32'h354), 32'h24681357)
    @(posedge clk);
    disp <= 32'h00000000;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_normal;
    t_block;
    t_chain;
    t_repeat;
    t_seq;
    t_disp;
    test_done;
  end
  // watchdog: the whole run needs far fewer than 20000 cycles
  initial begin
    #800000;
    fail_count++;
    test_done;
  end
endmodule // tb_event_triggered_data_transfer
`default_nettype wire
